// ### verilog/cfg_pins_regs.svh
// Purpose: constants for the strap and control pin sampling block
// Assumes: 100 MHz clock, 10 ns period
// Notes:   times in ns, counts derived from them
`ifndef CFG_PINS_REGS_SVH
`define CFG_PINS_REGS_SVH
`define CLK_PERIOD_NS        10
`define FILTER_TIME_NS       625
`define FILTER_CYCLES        (`FILTER_TIME_NS / `CLK_PERIOD_NS)
`define SHORT_FILTER_TIME_NS 5000
`define SHORT_FILTER_CYCLES  (`SHORT_FILTER_TIME_NS / `CLK_PERIOD_NS)
`define RESET_RATE_SEL       1'h0
`define RESET_LEVEL_SEL      1'h0
`define RESET_GATE           1'h1
`endif

// ### verilog/cfg_pins_pkg.sv
// Purpose: types for the strap and control pin sampling block
// Assumes: nothing
// Notes:   link settings travel as one struct
package cfg_pins_pkg;
  typedef struct packed {
    logic rate_fast;
    logic level_high;
  } link_cfg_s;
  typedef enum logic [1:0] {
    ST_CONFIG  = 2'b00,
    ST_STANDBY = 2'b01,
    ST_WAKE    = 2'b10,
    ST_NORMAL  = 2'b11
  } pwr_state_e;
endpackage : cfg_pins_pkg

// ### verilog/pin_deglitch.sv
// Purpose: up/reset deglitch counter on one synchronous input
// Assumes: input already synchronous to clock
// Notes:   output follows input once stable for CYCLES clocks
`timescale 1ns/100ps
`default_nettype none
module pin_deglitch #(
  parameter int CYCLES = 62,
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // pin
  input  wire logic pin_in,
  output logic      filt_out
);
  logic [7:0] cnt_reg;
  logic       last_reg;
  wire        edge_seen = pin_in != last_reg;
  wire        done      = cnt_reg >= 8'(CYCLES - 1);

  // [RL15] count up while stable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 8'h00;
      last_reg <= INIT;
      filt_out <= INIT;
    end else begin
      last_reg <= pin_in;
      if (edge_seen) begin
        cnt_reg <= 8'h00;
      end else if (!done) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else begin
        filt_out <= last_reg;
      end
    end
  end

  AST_FILTER_STABLE: assert property ( // [RL15]
    @(posedge clock) disable iff (!rst_n)
    $changed(filt_out) |-> $past(cnt_reg) >= 8'(CYCLES - 1))
    else $error("filter output changed before qualification");
endmodule : pin_deglitch
`default_nettype wire

// ### verilog/cfg_pin_sampler.sv
// Purpose: samples, deglitches and latches the strap and control pins
// Assumes: all pins synchronous to clock; power sequencing outside
// Notes:   queue-status pin shares its pad with the polarity strap
// Notes on behaviour
// [RL1] rate select 1 means fast bit time, 0 means slow bit time
// [RL2] slave, normal: rate captured filtered at chip select assertion
// [RL3] new rate hits receive path at once, transmit after frame ends
// [RL4] transmitter takes latest captured rate and level when idle
// [RL5] master: rate filtered continuously, no chip select capture
// [RL6] from stand-by rate captured during wake-up; host holds pin
// [RL7] at first power-up rate captured during that sequence
// [RL8] slave: queue-status high while receive queue holds a frame
// [RL9] master: clock idles at the polarity strap level
// [RL10] driven and read-back queue-status differ too long: go high-z
// [RL11] high-z stays until next wake-up sequence
// [RL12] slave: gate high at chip select pushes frame to transmit queue
// [RL13] gate low: discard input data, receive queue reads still work
// [RL14] gate captured only at chip select assertion
// [RL15] gate, level and rate pass 625 ns up/reset deglitch counters
// [RL16] master: phase strap picks first or second clock edge
// [RL17] level select 0 low amplitude, 1 high amplitude
// [RL18] slave: level applied to transmitter after current frame ends
// [RL19] master: level applied when a frame transmission starts
// [RL20] from stand-by level captured during wake-up; host holds pin
// [RL21] host releases level pin during stand-by
// [RL22] host sends dummy frames in burst reads with gate low
// [RL23] role strap latched once in config state, kept until power-up
// [RL24] queue-status short filter time is 5 us
// [RL25] deglitch counters run on the main clock
`timescale 1ns/100ps
`default_nettype none
`include "cfg_pins_regs.svh"
module cfg_pin_sampler #(
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter int SHORT_CYCLES  = `SHORT_FILTER_CYCLES
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // power sequencing events
  input  wire logic                    config_latch,
  input  wire logic                    wake_active,
  input  wire logic                    normal_state,
  // straps and control pins
  input  wire logic                    role_strap,
  input  wire logic                    link_rate_select,
  input  wire logic                    tx_level_select,
  input  wire logic                    transmit_gate,
  input  wire logic                    chip_select_low,
  // shared queue-status / polarity pad
  input  wire logic                    status_pad_in,
  output logic                         rx_queue_nonempty,
  output logic                         status_pad_oe,
  // link state
  input  wire logic                    rx_queue_has_frame,
  input  wire logic                    tx_busy,
  input  wire logic                    tx_frame_start,
  // results
  output logic                         role_master,
  output logic                         clock_idle_polarity,
  output logic                         sample_edge_phase,
  output logic                         clock_idle_level,
  output cfg_pins_pkg::link_cfg_s      rx_cfg,
  output cfg_pins_pkg::link_cfg_s      tx_cfg,
  output logic                         frame_to_tx,
  output logic                         status_shorted
);
  import cfg_pins_pkg::*;

  // reset release through two flops
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rstn = rst_s2_reg;

  // [RL15] [RL25] three filters on the main clock
  logic rate_f, level_f, gate_f;
  pin_deglitch #(.CYCLES(FILTER_CYCLES), .INIT(`RESET_RATE_SEL)) u_rate (
    .clock    (clock),
    .rst_n    (rstn),
    .pin_in   (link_rate_select),
    .filt_out (rate_f)
  );
  pin_deglitch #(.CYCLES(FILTER_CYCLES), .INIT(`RESET_LEVEL_SEL)) u_level (
    .clock    (clock),
    .rst_n    (rstn),
    .pin_in   (tx_level_select),
    .filt_out (level_f)
  );
  pin_deglitch #(.CYCLES(FILTER_CYCLES), .INIT(`RESET_GATE)) u_gate (
    .clock    (clock),
    .rst_n    (rstn),
    .pin_in   (transmit_gate),
    .filt_out (gate_f)
  );

  // chip select assertion edge
  logic cs_low_d_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cs_low_d_reg <= 1'b0;
    else       cs_low_d_reg <= chip_select_low;
  end
  wire cs_assert = chip_select_low & ~cs_low_d_reg;

  // [RL23] role and straps latched once in config state
  logic role_reg, pol_reg, phase_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      role_reg  <= 1'b0;
      pol_reg   <= 1'b0;
      phase_reg <= 1'b0;
    end else if (config_latch) begin
      role_reg  <= role_strap;
      pol_reg   <= status_pad_in;
      phase_reg <= transmit_gate;
    end
  end

  wire slave_capture = normal_state & ~role_reg & cs_assert;
  wire master_track  = normal_state & role_reg;
  // [RL6] [RL7] [RL20] capture during wake-up and first power-up
  wire seq_capture   = wake_active | config_latch;

  // [RL2] [RL5] latest captured link settings
  link_cfg_s cap_reg, cap_next;
  always_comb begin
    cap_next = cap_reg;
    if (seq_capture | master_track | slave_capture) begin
      cap_next.rate_fast  = rate_f;
      // [RL17] set selects high amplitude
      cap_next.level_high = level_f;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cap_reg <= '{`RESET_RATE_SEL, `RESET_LEVEL_SEL};
    else       cap_reg <= cap_next;
  end

  // [RL14] gate latched only at chip select assertion
  logic gate_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)              gate_reg <= `RESET_GATE;
    else if (slave_capture) gate_reg <= gate_f;
  end

  // [RL12] [RL13] slave frame goes to transmit queue only if gate was high; master frames always go
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) frame_to_tx <= 1'b0;
    else       frame_to_tx <= role_reg | gate_reg;
  end

  // [RL3] [RL18] [RL19] [RL4] transmit settings update when allowed
  wire tx_update_slave  = ~role_reg & ~tx_busy;
  wire tx_update_master = role_reg & (tx_frame_start | ~tx_busy);
  link_cfg_s tx_next;
  assign tx_next = (tx_update_slave | tx_update_master) ? cap_next : tx_cfg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_cfg <= '{`RESET_RATE_SEL, `RESET_LEVEL_SEL};
      rx_cfg <= '{`RESET_RATE_SEL, `RESET_LEVEL_SEL};
    end else begin
      tx_cfg <= tx_next;
      // [RL3] receive path follows capture at once
      rx_cfg <= cap_next;
    end
  end

  // [RL9] [RL16] master serial clock idle level and phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      role_master         <= 1'b0;
      clock_idle_polarity <= 1'b0;
      sample_edge_phase   <= 1'b0;
      clock_idle_level    <= 1'b0;
    end else begin
      role_master         <= role_reg;
      clock_idle_polarity <= pol_reg;
      sample_edge_phase   <= phase_reg;
      clock_idle_level    <= role_reg & pol_reg;
    end
  end

  // [RL10] [RL24] short detection on the queue-status pad
  logic [15:0] short_cnt_reg;
  logic        short_reg;
  wire drive_en   = normal_state & ~role_reg & ~short_reg;
  wire mismatch   = status_pad_oe & (status_pad_in != rx_queue_nonempty);
  wire short_hit  = short_cnt_reg >= 16'(SHORT_CYCLES - 1);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      short_cnt_reg <= 16'h0000;
      short_reg     <= 1'b0;
    end else begin
      if (!mismatch)      short_cnt_reg <= 16'h0000;
      else if (!short_hit) short_cnt_reg <= short_cnt_reg + 16'h0001;
      // [RL11] only a wake-up clears the short
      if (wake_active)                short_reg <= 1'b0;
      else if (mismatch && short_hit) short_reg <= 1'b1;
    end
  end

  // [RL8] queue-status output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_queue_nonempty <= 1'b0;
      status_pad_oe     <= 1'b0;
      status_shorted    <= 1'b0;
    end else begin
      rx_queue_nonempty <= drive_en & rx_queue_has_frame;
      status_pad_oe     <= drive_en & ~(mismatch & short_hit);
      status_shorted    <= short_reg | (mismatch & short_hit);
    end
  end

  AST_GATE_HOLD: assert property ( // [RL14]
    @(posedge clock) disable iff (!rstn)
    !slave_capture |=> $stable(gate_reg))
    else $error("gate changed outside chip select assertion");
  AST_GATE_DISCARD: assert property ( // [RL13]
    @(posedge clock) disable iff (!rstn)
    (!role_reg && !gate_reg) |=> !frame_to_tx)
    else $error("frame kept although gate was low");
  AST_TX_HOLD_BUSY: assert property ( // [RL3]
    @(posedge clock) disable iff (!rstn)
    (!role_reg && tx_busy) |=> $stable(tx_cfg))
    else $error("slave transmit settings changed mid frame");
  AST_TX_IDLE_TAKE: assert property ( // [RL4]
    @(posedge clock) disable iff (!rstn)
    (!role_reg && !tx_busy) |=> tx_cfg == $past(cap_next))
    else $error("idle transmitter missed latest settings");
  AST_RX_FOLLOW: assert property ( // [RL2]
    @(posedge clock) disable iff (!rstn)
    slave_capture |=> rx_cfg.rate_fast == $past(rate_f))
    else $error("receive rate not taken at chip select");
  AST_RX_LEVEL: assert property ( // [RL17]
    @(posedge clock) disable iff (!rstn)
    slave_capture |=> rx_cfg.level_high == $past(level_f))
    else $error("level not taken at chip select");
  AST_SLAVE_RATE_HOLD: assert property ( // [RL2]
    @(posedge clock) disable iff (!rstn)
    (normal_state && !role_reg && !cs_assert && !seq_capture)
      |=> $stable(cap_reg))
    else $error("slave settings changed without chip select");

  // short detection and queue-status pad
  AST_SHORT_OFF: assert property ( // [RL10]
    @(posedge clock) disable iff (!rstn)
    (mismatch && short_hit && !wake_active) |=> !status_pad_oe)
    else $error("queue-status pad still driven after short");
  AST_NO_EARLY_OFF: assert property ( // [RL10]
    @(posedge clock) disable iff (!rstn)
    (drive_en && !(mismatch && short_hit)) |=> status_pad_oe)
    else $error("queue-status pad released too early");
  AST_SHORT_STICKY: assert property ( // [RL11]
    @(posedge clock) disable iff (!rstn)
    (short_reg && !wake_active) |=> short_reg)
    else $error("short cleared without wake-up");
  AST_SHORT_CLEAR: assert property ( // [RL11]
    @(posedge clock) disable iff (!rstn)
    wake_active |=> !short_reg)
    else $error("short not cleared by wake-up");
  AST_STATUS_LEVEL: assert property ( // [RL8]
    @(posedge clock) disable iff (!rstn)
    drive_en |=> rx_queue_nonempty == $past(rx_queue_has_frame))
    else $error("queue-status does not follow queue");
  AST_MASTER_NO_DRIVE: assert property ( // [RL8]
    @(posedge clock) disable iff (!rstn)
    role_reg |=> !status_pad_oe)
    else $error("queue-status pad driven in master role");

  // straps, sequences and master behaviour
  AST_IDLE_CLK: assert property ( // [RL9]
    @(posedge clock) disable iff (!rstn)
    role_reg |=> clock_idle_level == $past(pol_reg))
    else $error("master clock idle level wrong");
  AST_ROLE_KEEP: assert property ( // [RL23]
    @(posedge clock) disable iff (!rstn)
    !config_latch |=> $stable(role_reg))
    else $error("role changed outside config latch");
  AST_WAKE_RATE: assert property ( // [RL6]
    @(posedge clock) disable iff (!rstn)
    wake_active |=> cap_reg.rate_fast == $past(rate_f))
    else $error("rate not captured during wake-up");
  AST_WAKE_LEVEL: assert property ( // [RL20]
    @(posedge clock) disable iff (!rstn)
    wake_active |=> cap_reg.level_high == $past(level_f))
    else $error("level not captured during wake-up");
  AST_POWERUP_RATE: assert property ( // [RL7]
    @(posedge clock) disable iff (!rstn)
    config_latch |=> cap_reg.rate_fast == $past(rate_f))
    else $error("rate not captured during power-up");
  AST_MASTER_TRACK: assert property ( // [RL5]
    @(posedge clock) disable iff (!rstn)
    master_track |=> cap_reg.level_high == $past(level_f))
    else $error("master level not tracking filter");
  AST_MASTER_START: assert property ( // [RL19]
    @(posedge clock) disable iff (!rstn)
    (role_reg && tx_frame_start) |=> tx_cfg == $past(cap_next))
    else $error("master settings not applied at frame start");
  AST_MASTER_HOLD: assert property ( // [RL19]
    @(posedge clock) disable iff (!rstn)
    (role_reg && tx_busy && !tx_frame_start) |=> $stable(tx_cfg))
    else $error("master settings changed inside a frame");

  COV_SLAVE_CAP: cover property (@(posedge clock) disable iff (!rstn)
    slave_capture ##1 tx_busy);
  COV_SHORT: cover property (@(posedge clock) disable iff (!rstn)
    $rose(short_reg));
  COV_GATE_LOW: cover property (@(posedge clock) disable iff (!rstn)
    slave_capture && !gate_f);
  COV_MASTER_START: cover property (@(posedge clock) disable iff (!rstn)
    master_track && tx_frame_start);
  COV_WAKE_CLEAR: cover property (@(posedge clock) disable iff (!rstn)
    wake_active && short_reg);
endmodule : cfg_pin_sampler
`default_nettype wire

// ### tb/host_pad_model.sv
// Purpose: host side of the shared status/polarity pad
// Assumes: pad has an internal pull-down
// Notes:   short_en forces the pad to short_lvl, beating all drivers
`timescale 1ns/100ps
`default_nettype none
module host_pad_model (
  // device side
  input  wire logic pad_oe,
  input  wire logic pad_out,
  // host side
  input  wire logic short_en,
  input  wire logic short_lvl,
  input  wire logic strap_drive,
  input  wire logic strap_lvl,
  // resolved level
  output logic      pad_level
);
  // fault injection; undriven pad falls to the pull-down
  assign pad_level = short_en ? short_lvl :
                     pad_oe ? pad_out :
                     strap_drive ? strap_lvl : 1'h0;
endmodule : host_pad_model
`default_nettype wire

// ### tb/cfg_pin_sampler_tb.sv
// Purpose: self-checking bench for the strap and control pin sampler
// Assumes: deglitch filter 4 cycles, short filter 8 cycles
// Notes:   transmitter state is driven directly by the bench
`timescale 1ns/100ps
`default_nettype none
module cfg_pin_sampler_tb;
  import cfg_pins_pkg::*;
  localparam int FC = 4;
  localparam int SC = 8;
  logic clock, rst_n, config_latch, wake_active, normal_state, role_strap;
  logic link_rate_select, tx_level_select, transmit_gate, chip_select_low;
  logic rx_queue_has_frame, tx_busy, tx_frame_start, short_en, strap_drive;
  logic strap_lvl, pad, q_ne, pad_oe, role_m, pol, phase, idle_lvl;
  logic frame_to_tx, shorted;
  link_cfg_s rx_cfg, tx_cfg;
  int failures, total_checks, cyc;
  cfg_pin_sampler #(.FILTER_CYCLES(FC), .SHORT_CYCLES(SC)) i_dut (
    .clock(clock), .rst_n(rst_n), .config_latch(config_latch),
    .wake_active(wake_active), .normal_state(normal_state),
    .role_strap(role_strap), .link_rate_select(link_rate_select),
    .tx_level_select(tx_level_select), .transmit_gate(transmit_gate),
    .chip_select_low(chip_select_low), .status_pad_in(pad),
    .rx_queue_nonempty(q_ne), .status_pad_oe(pad_oe),
    .rx_queue_has_frame(rx_queue_has_frame), .tx_busy(tx_busy),
    .tx_frame_start(tx_frame_start), .role_master(role_m),
    .clock_idle_polarity(pol), .sample_edge_phase(phase),
    .clock_idle_level(idle_lvl), .rx_cfg(rx_cfg), .tx_cfg(tx_cfg),
    .frame_to_tx(frame_to_tx), .status_shorted(shorted));
  host_pad_model i_host (.pad_oe(pad_oe), .pad_out(q_ne),
    .short_en(short_en), .short_lvl(1'h0), .strap_drive(strap_drive),
    .strap_lvl(strap_lvl), .pad_level(pad));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  task check1(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check1
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // two frame captures with a busy transmitter, latest one wins
  task t_capture;
    link_rate_select = 1'h1;
    tx_busy = 1'h1;
    tick(FC + 3);
    chip_select_low = 1'h1;
    tick(3);
    check1(rx_cfg.rate_fast, 1'h1, "rx rate");
    check1(tx_cfg.rate_fast, 1'h0, "tx rate early");
    chip_select_low = 1'h0;
    tx_level_select = 1'h1;
    tick(FC + 3);
    chip_select_low = 1'h1;
    tick(3);
    check1(tx_cfg.level_high, 1'h0, "tx level early");
    tx_busy = 1'h0;
    tick(2);
    check1(tx_cfg.rate_fast, 1'h1, "tx rate");
    check1(tx_cfg.level_high, 1'h1, "tx level latest");
    chip_select_low = 1'h0;
    $display("capture done");
  endtask : t_capture
  // gate low discards, mid-frame changes ignored, short glitch filtered
  task t_gate;
    transmit_gate = 1'h0;
    tick(FC + 3);
    // frame sent with the gate low stands for a dummy frame
    chip_select_low = 1'h1;
    tick(3);
    check1(frame_to_tx, 1'h0, "gate low");
    transmit_gate = 1'h1;
    tick(FC + 3);
    check1(frame_to_tx, 1'h0, "mid-frame gate");
    chip_select_low = 1'h0;
    link_rate_select = 1'h0;
    tick(1);
    chip_select_low = 1'h1;
    tick(2);
    link_rate_select = 1'h1;
    tick(1);
    check1(frame_to_tx, 1'h1, "gate high");
    check1(rx_cfg.rate_fast, 1'h1, "glitch");
    chip_select_low = 1'h0;
    $display("gate done");
  endtask : t_gate
  // queue status, short, re-enable at wake-up
  task t_status;
    rx_queue_has_frame = 1'h1;
    tick(3);
    check1(q_ne, 1'h1, "status high");
    check1(pad_oe, 1'h1, "status driven");
    short_en = 1'h1;
    tick(SC - 1);
    check1(pad_oe, 1'h1, "short too early");
    tick(5);
    check1(pad_oe, 1'h0, "short high-z");
    check1(shorted, 1'h1, "short flag");
    short_en = 1'h0;
    link_rate_select = 1'h0;
    tick(5);
    check1(pad_oe, 1'h0, "stays high-z");
    check1(rx_cfg.rate_fast, 1'h1, "rate held");
    // rate pin held low through the wake-up
    wake_active = 1'h1;
    tick(2);
    wake_active = 1'h0;
    tick(3);
    check1(pad_oe, 1'h1, "re-enabled");
    check1(shorted, 1'h0, "short cleared");
    check1(rx_cfg.rate_fast, 1'h0, "wake-up rate");
    rx_queue_has_frame = 1'h0;
    tick(3);
    check1(q_ne, 1'h0, "status low");
    $display("status done");
  endtask : t_status
  // master straps and continuous rate tracking
  task t_master;
    normal_state = 1'h0; role_strap = 1'h1; strap_drive = 1'h1;
    strap_lvl = 1'h1; transmit_gate = 1'h0;
    config_latch = 1'h1;
    tick(3);
    config_latch = 1'h0; normal_state = 1'h1;
    tick(3);
    check1(role_m, 1'h1, "role");
    check1(pol, 1'h1, "polarity");
    check1(idle_lvl, 1'h1, "idle level");
    check1(phase, 1'h0, "phase");
    role_strap = 1'h0;
    link_rate_select = 1'h1;
    tick(FC + 4);
    check1(role_m, 1'h1, "role kept");
    check1(rx_cfg.rate_fast, 1'h1, "master rate");
    check1(frame_to_tx, 1'h1, "master gate");
    tx_busy = 1'h1;
    tx_level_select = 1'h0;
    tick(FC + 3);
    check1(tx_cfg.level_high, 1'h1, "level before start");
    tx_frame_start = 1'h1;
    tick(1);
    tx_frame_start = 1'h0;
    tx_busy = 1'h0;
    check1(tx_cfg.level_high, 1'h0, "level at start");
    $display("master done");
  endtask : t_master
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'h0; config_latch = 1'h0; wake_active = 1'h0;
    normal_state = 1'h0; role_strap = 1'h0; link_rate_select = 1'h0;
    tx_level_select = 1'h0; transmit_gate = 1'h1; chip_select_low = 1'h0;
    rx_queue_has_frame = 1'h0; tx_busy = 1'h0; tx_frame_start = 1'h0;
    short_en = 1'h0; strap_drive = 1'h0; strap_lvl = 1'h0;
    tick(6);
    rst_n = 1'h1;
    tick(3);
    // straps held steady through the power-up latch
    config_latch = 1'h1;
    tick(3);
    config_latch = 1'h0; normal_state = 1'h1;
    tick(2);
    check1(role_m, 1'h0, "slave role");
    check1(idle_lvl, 1'h0, "slave idle");
    t_capture();
    t_gate();
    t_status();
    t_master();
    final_report();
  end
endmodule : cfg_pin_sampler_tb
`default_nettype wire
